// ==== amp_seq_pkg.sv ====
// Overview of operation
// - At power-up run self-test, then start the heater warm-up delay.
// - Warm-up over with no pending request: light standby, high voltage kept off.
// - In standby a transmit/standby key press starts the beam-on sequence.
// - Beam-on sequence completing cleanly enters transmit with high voltage on.
// - Key press during warm-up is remembered; standby lamp flashes meanwhile.
// - Pending request at warm-up end starts beam-on sequence automatically.
// - Beam off over one minute lowers heater command by ten percent.
// - Outage of a few seconds resumes the previous state at once; beam states restart beam-on.
// - Longer outage: warm-up proportional to outage, capped at three minutes, then resume.
// - Fault in transmit moves to fault state and lights fault lamp.
// - Fault under four seconds is transient; under three in twenty seconds recycles.
// - Each recycled transient fault waits one second before transmit.
// - Failed recycle keeps fault lamp lit until user reset.
// - Fault over four seconds or three in twenty seconds latches fault.
// - Latched fault lamp stays lit until reset command or power cycle.
// - Reset with fault cleared gives standby; another reset resumes transmitting.
// - A fault in beam-on or transmit lights fault lamp; any fault outside an outage records a readable fault summary.
// - In transmit, forward power below user low set point raises low-power alarm.
// - Reflected-power excess is a fault input taking part in recycle logic.
package amp_seq_pkg;
    // One tick is one millisecond of the 200 MHz clock
    localparam int CLK_MHZ         = 200;
    localparam int TICK_US         = 1000;
    localparam int TICK_CYCLES     = TICK_US * CLK_MHZ;
    localparam int TICKS_PER_S     = 1000000 / TICK_US;
    localparam int SELFTEST_MS     = 10;
    localparam int BOS_MS          = 100;
    localparam int WARMUP_MAX_S    = 180;
    localparam int BEAMOFF_S       = 60;
    localparam int SHORT_OUT_S     = 3;
    localparam int TRANSIENT_S     = 4;
    localparam int WINDOW_S        = 20;
    localparam int RECYCLE_S       = 1;
    localparam int SELFTEST_TK     = SELFTEST_MS * TICKS_PER_S / 1000;
    localparam int BOS_TK          = BOS_MS * TICKS_PER_S / 1000;
    localparam int WARMUP_TK       = WARMUP_MAX_S * TICKS_PER_S;
    localparam int BEAMOFF_TK      = BEAMOFF_S * TICKS_PER_S;
    localparam int SHORT_OUT_TK    = SHORT_OUT_S * TICKS_PER_S;
    localparam int TRANSIENT_TK    = TRANSIENT_S * TICKS_PER_S;
    localparam int WINDOW_TK       = WINDOW_S * TICKS_PER_S;
    localparam int RECYCLE_TK      = RECYCLE_S * TICKS_PER_S;
    localparam int FLASH_BIT       = 8;
    localparam int TW              = 18;
    localparam logic [6:0] HEAT_FULL_PCT = 7'h64;
    localparam logic [6:0] HEAT_LOW_PCT  = 7'h5a;
    // Control source select codes
    localparam logic [1:0] SRC_LOCAL  = 2'h0;
    localparam logic [1:0] SRC_REMOTE = 2'h1;
    typedef enum logic [3:0] {
        S_SELF, S_WARM, S_STBY, S_BEAM, S_TX, S_FREC, S_RWAIT, S_LATCH, S_OUT
    } seq_state_t;
endpackage : amp_seq_pkg

// ==== amplifier_beam_fault_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module amplifier_beam_fault_sequencer
    import amp_seq_pkg::*;
#(
    parameter int NF          = 8,
    parameter int PW          = 12,
    parameter int TICK_CYC    = TICK_CYCLES,
    parameter int SELF_T      = SELFTEST_TK,
    parameter int BOS_T       = BOS_TK,
    parameter int WARM_T      = WARMUP_TK,
    parameter int BOFF_T      = BEAMOFF_TK,
    parameter int SHORT_T     = SHORT_OUT_TK,
    parameter int TRANS_T     = TRANSIENT_TK,
    parameter int WIN_T       = WINDOW_TK,
    parameter int RECYC_T     = RECYCLE_TK
)(
    input  wire logic          sys_clk_in,
    input  wire logic          rstn_in,
    input  wire logic          ac_ok_in,
    input  wire logic [1:0]    ctl_src_in,
    input  wire logic          xmit_key_local_in,
    input  wire logic          xmit_key_remote_in,
    input  wire logic          xmit_key_host_in,
    input  wire logic          reset_key_local_in,
    input  wire logic          reset_key_remote_in,
    input  wire logic          reset_key_host_in,
    input  wire logic [NF-1:0] fault_in,
    input  wire logic          refl_fault_in,
    input  wire logic [PW-1:0] fwd_power_in,
    input  wire logic [PW-1:0] low_setpoint_in,
    output logic               hv_enable_out,
    output logic               standby_led_out,
    output logic               transmit_led_out,
    output logic               fault_led_out,
    output logic [6:0]         heater_pct_out,
    output logic               low_rf_alarm_out,
    output logic [NF:0]        fault_summary_out
);
    localparam logic [TW-1:0] TMAX = '1;

    // Every timer shares one width, so the longest count must fit it
    if (TICK_CYC < 1 || TICK_CYC > 2**TW || WARM_T >= 2**TW || WIN_T >= 2**TW ||
        BOFF_T >= 2**TW || SHORT_T < 1 || NF < 1 || PW < 1)
    begin : g_bad_param
        $error("amplifier_beam_fault_sequencer: parameter out of range");
    end

    typedef struct packed {
        seq_state_t          st;
        seq_state_t          prev;
        logic [TW-1:0]       pre;
        logic                tick;
        logic [TW-1:0]       tmr;
        logic [TW-1:0]       boff;
        logic [TW-1:0]       wu_len;
        logic                pend;
        logic                after_latch;
        logic [2:0][TW-1:0]  age;
        logic [2:0]          vld;
        logic                key_q;
        logic                rst_q;
        logic                hv;
        logic                sb_led;
        logic                tx_led;
        logic                flt_led;
        logic [6:0]          heat;
        logic                low_rf;
        logic [NF:0]         summ;
    } seq_regs_t;

    seq_regs_t r_q;
    seq_regs_t r_d;

    // Pick the key of the active control source
    function automatic logic pick(input logic [1:0] src, input logic l,
                                  input logic m, input logic h);
        pick = (src == SRC_LOCAL) ? l : (src == SRC_REMOTE) ? m : h;
    endfunction : pick

    // True when at least two of three bits are set
    function automatic logic two_of(input logic [2:0] v);
        two_of = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : two_of

    // States in which the beam was on or meant to be
    function automatic logic xmit_like(input seq_state_t s);
        xmit_like = (s == S_BEAM) || (s == S_TX) || (s == S_FREC) || (s == S_RWAIT);
    endfunction : xmit_like

    logic key_lvl;
    logic rst_lvl;
    logic key_ev;
    logic rst_ev;
    logic any_fault;

    // Operator command selection and press detection
    // source select
    assign key_lvl   = pick(ctl_src_in, xmit_key_local_in, xmit_key_remote_in,
                            xmit_key_host_in);
    assign rst_lvl   = pick(ctl_src_in, reset_key_local_in, reset_key_remote_in,
                            reset_key_host_in);
    assign key_ev    = key_lvl & ~r_q.key_q;
    assign rst_ev    = rst_lvl & ~r_q.rst_q;
    assign any_fault = (|fault_in) | refl_fault_in;

    // Next-state logic for the whole sequencer
    always_comb
    begin
        r_d       = r_q;
        r_d.key_q = key_lvl;
        r_d.rst_q = rst_lvl;
        r_d.tick = 1'b0;
        if (r_q.pre >= TW'(TICK_CYC - 1))
        begin
            r_d.pre  = '0;
            r_d.tick = 1'b1;
        end
        else
        begin
            r_d.pre = r_q.pre + 1'b1;
        end
        if (r_q.tick && r_q.tmr != TMAX)
        begin
            r_d.tmr = r_q.tmr + 1'b1;
        end
        for (int i = 0; i < 3; i++)
        begin
            if (r_q.tick && r_q.vld[i])
            begin
                r_d.age[i] = r_q.age[i] + 1'b1;
                if (r_q.age[i] >= TW'(WIN_T - 1))
                begin
                    r_d.vld[i] = 1'b0;
                end
            end
        end
        if (r_q.st != S_OUT)
        begin
            r_d.summ = r_q.summ | {refl_fault_in, fault_in};
        end

        // Loss of prime power overrides every state
        if (!ac_ok_in && r_q.st != S_OUT)
        begin
            r_d.prev = r_q.st;
            r_d.st   = S_OUT;
        end
        else
        begin
            case (r_q.st)
                S_SELF:
                begin
                    if (r_q.tmr >= TW'(SELF_T))
                    begin
                        r_d.wu_len = TW'(WARM_T);
                        r_d.st     = S_WARM;
                    end
                end
                S_WARM:
                begin
                    if (key_ev)
                    begin
                        r_d.pend = 1'b1;
                    end
                    if (r_q.tmr >= r_q.wu_len)
                    begin
                        r_d.st   = (r_q.pend || key_ev) ? S_BEAM : S_STBY;
                        r_d.pend = 1'b0;
                    end
                end
                S_STBY:
                begin
                    if (key_ev || (rst_ev && r_q.after_latch))
                    begin
                        r_d.st          = S_BEAM;
                        r_d.after_latch = 1'b0;
                    end
                    else if (rst_ev)
                    begin
                        r_d.summ = {refl_fault_in, fault_in}; // A fault in the clearing cycle wins
                    end
                end
                S_BEAM:
                begin
                    if (any_fault)
                    begin
                        r_d.st = S_LATCH;
                    end
                    else if (key_ev)
                    begin
                        r_d.st = S_STBY;
                    end
                    else if (r_q.tmr >= TW'(BOS_T))
                    begin
                        r_d.st = S_TX;
                    end
                end
                S_TX:
                begin
                    if (any_fault)
                    begin
                        // Shift the aged copies so an expiring entry is not revived
                        r_d.age = {r_d.age[1:0], TW'(0)};
                        r_d.vld = {r_d.vld[1:0], 1'b1};
                        r_d.st  = two_of(r_q.vld) ? S_LATCH : S_FREC;
                    end
                    else if (key_ev)
                    begin
                        r_d.st = S_STBY;
                    end
                end
                S_FREC:
                begin
                    if (r_q.tmr >= TW'(TRANS_T))
                    begin
                        r_d.st = S_LATCH;
                    end
                    else if (!any_fault)
                    begin
                        r_d.st = S_RWAIT;
                    end
                end
                S_RWAIT:
                begin
                    if (any_fault)
                    begin
                        r_d.st = S_LATCH;
                    end
                    else if (r_q.tmr >= TW'(RECYC_T))
                    begin
                        r_d.st = S_TX;
                    end
                end
                S_LATCH:
                begin
                    if (rst_ev && !any_fault)
                    begin
                        r_d.st          = S_STBY;
                        r_d.after_latch = 1'b1;
                        r_d.summ        = '0;
                    end
                end
                S_OUT:
                begin
                    if (ac_ok_in)
                    begin
                        if (r_q.tmr < TW'(SHORT_T))
                        begin
                            r_d.st = xmit_like(r_q.prev) ? S_BEAM : r_q.prev;
                        end
                        else
                        begin
                            r_d.wu_len = (r_q.tmr > TW'(WARM_T)) ? TW'(WARM_T) : r_q.tmr;
                            r_d.pend   = r_q.pend | xmit_like(r_q.prev);
                            r_d.st     = S_WARM;
                        end
                    end
                end
                default:
                begin
                    r_d.st = S_SELF;
                end
            endcase
        end
        if (r_d.st != r_q.st)
        begin
            r_d.tmr = '0;
        end
        if (r_d.st inside {S_STBY, S_FREC, S_RWAIT, S_LATCH})
        begin
            if (r_q.tick && r_q.boff != TMAX)
            begin
                r_d.boff = r_q.boff + 1'b1;
            end
        end
        else
        begin
            r_d.boff = '0;
        end
        r_d.heat    = (r_q.boff > TW'(BOFF_T)) ? HEAT_LOW_PCT : HEAT_FULL_PCT;
        // Indicators follow the next state so they change with it
        r_d.hv      = (r_d.st == S_BEAM) || (r_d.st == S_TX);
        r_d.tx_led  = (r_d.st == S_TX);
        r_d.flt_led = r_d.st inside {S_FREC, S_RWAIT, S_LATCH};
        // flashing standby lamp
        // Lamp phase follows warm-up timer bit FLASH_BIT, lit while that bit is low
        r_d.sb_led  = (r_d.st == S_STBY) ||
                      ((r_d.st == S_WARM) && r_d.pend && !r_q.tmr[FLASH_BIT]);
        r_d.low_rf  = (r_d.st == S_TX) && (fwd_power_in < low_setpoint_in);
    end

    // Synchronous reset doubles as control power-on
    // timers cleared by reset
    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            r_q      <= '0;
            r_q.st   <= S_SELF;
            r_q.prev <= S_SELF;
            r_q.heat <= HEAT_FULL_PCT;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign hv_enable_out     = r_q.hv;
    assign standby_led_out   = r_q.sb_led;
    assign transmit_led_out  = r_q.tx_led;
    assign fault_led_out     = r_q.flt_led;
    assign heater_pct_out    = r_q.heat;
    assign low_rf_alarm_out  = r_q.low_rf;
    assign fault_summary_out = r_q.summ;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    self_to_warm_a: assert property (r_q.st == S_SELF && r_q.tmr >= TW'(SELF_T) && ac_ok_in
        |=> r_q.st == S_WARM && r_q.wu_len == TW'(WARM_T))
        else $error("self-test did not hand over to warm-up");
    warm_end_a: assert property (r_q.st == S_WARM && r_q.tmr >= r_q.wu_len && ac_ok_in
        |=> (r_q.st == S_BEAM) == $past(r_q.pend || key_ev) && standby_led_out ==
        (r_q.st == S_STBY))
        else $error("warm-up end went to the wrong state");
    stby_key_a: assert property (r_q.st == S_STBY && key_ev && ac_ok_in
        |=> r_q.st == S_BEAM && hv_enable_out)
        else $error("key in standby did not start beam-on");
    beam_done_a: assert property (r_q.st == S_BEAM && r_q.tmr >= TW'(BOS_T) && ac_ok_in &&
        !any_fault && !key_ev |=> transmit_led_out && hv_enable_out)
        else $error("beam-on did not reach transmit");
    tx_fault_a: assert property (r_q.st == S_TX && any_fault && ac_ok_in
        |=> fault_led_out && !transmit_led_out)
        else $error("transmit fault not shown");
    long_fault_a: assert property (r_q.st == S_FREC && r_q.tmr >= TW'(TRANS_T) && ac_ok_in
        |=> r_q.st == S_LATCH)
        else $error("long fault did not latch");
    window_a: assert property (r_q.st == S_TX && any_fault && ac_ok_in && two_of(r_q.vld)
        |=> r_q.st == S_LATCH)
        else $error("third fault in window did not latch");
    recycle_a: assert property ($rose(r_q.st == S_TX) && $past(r_q.st) == S_RWAIT
        |-> $past(r_q.tmr) >= TW'(RECYC_T))
        else $error("recycle entered transmit too early");
    latch_hold_a: assert property (r_q.st == S_LATCH && ac_ok_in && !(rst_ev && !any_fault)
        |=> r_q.st == S_LATCH && fault_led_out)
        else $error("latched fault released without reset");
    heater_a: assert property (heater_pct_out == HEAT_LOW_PCT
        |-> $past(r_q.boff) > TW'(BOFF_T))
        else $error("heater lowered too soon");
    low_rf_a: assert property (r_q.st == S_TX && fwd_power_in < low_setpoint_in && ac_ok_in
        && !any_fault && !key_ev |=> low_rf_alarm_out)
        else $error("low power alarm missing");
    short_out_a: assert property (r_q.st == S_OUT && ac_ok_in && r_q.tmr < TW'(SHORT_T)
        |=> r_q.st == r_q.prev || (r_q.st == S_BEAM && xmit_like(r_q.prev)))
        else $error("short outage did not resume");

    tx_reached_c: cover property (r_q.st == S_BEAM ##1 r_q.st == S_TX);
    recycled_c: cover property (r_q.st == S_RWAIT ##1 r_q.st == S_TX);
    latched_c: cover property (r_q.st == S_FREC ##1 r_q.st == S_LATCH);
    flash_c: cover property (r_q.st == S_WARM && standby_led_out);
endmodule : amplifier_beam_fault_sequencer
`default_nettype wire

// ==== operator_panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module operator_panel_model (
    input  wire logic       sys_clk_in,
    output var  logic [1:0] ctl_src_out,
    output var  logic [2:0] xmit_key_out,
    output var  logic [2:0] reset_key_out
);
    // Keys idle low; one operator desk is in charge at a time
    initial
    begin
        ctl_src_out   = 2'h0;
        xmit_key_out  = 3'h0;
        reset_key_out = 3'h0;
    end

    // source select, key press
    // Source settles a cycle before the key so the edge is never ambiguous
    task automatic press(input logic rst, input logic [1:0] src);
        int k;
        k = (src > 2'h1) ? 2 : int'(src);
        @(negedge sys_clk_in);
        ctl_src_out = src;
        @(negedge sys_clk_in);
        if (rst)
            reset_key_out[k] = 1'b1;
        else
            xmit_key_out[k] = 1'b1;
        repeat (2) @(negedge sys_clk_in);
        xmit_key_out  = 3'h0;
        reset_key_out = 3'h0;
    endtask : press
endmodule : operator_panel_model
`default_nettype wire

// ==== amplifier_beam_fault_sequencer_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module amplifier_beam_fault_sequencer_test;
    import amp_seq_pkg::*;
    localparam int NF = 8;
    localparam int TC = 4;
    logic        sys_clk, rstn, ac_ok, refl, hv, stby, tx, flt, lowrf;
    logic [1:0]  src;
    logic [2:0]  xk, rk;
    logic [7:0]  fault;
    logic [11:0] fwd, setp;
    logic [6:0]  heat;
    logic [8:0]  summ;
    int          err_total, comparisons, cycles;

    // Short timer settings keep the run to a few thousand cycles
    amplifier_beam_fault_sequencer #(.TICK_CYC(TC), .SELF_T(2), .BOS_T(3), .WARM_T(20),
        .BOFF_T(10), .SHORT_T(3), .TRANS_T(8), .WIN_T(30), .RECYC_T(4)) uut (
        .sys_clk_in(sys_clk), .rstn_in(rstn), .ac_ok_in(ac_ok), .ctl_src_in(src),
        .xmit_key_local_in(xk[0]), .xmit_key_remote_in(xk[1]), .xmit_key_host_in(xk[2]),
        .reset_key_local_in(rk[0]), .reset_key_remote_in(rk[1]), .reset_key_host_in(rk[2]),
        .fault_in(fault), .refl_fault_in(refl), .fwd_power_in(fwd), .low_setpoint_in(setp),
        .hv_enable_out(hv), .standby_led_out(stby), .transmit_led_out(tx),
        .fault_led_out(flt), .heater_pct_out(heat), .low_rf_alarm_out(lowrf),
        .fault_summary_out(summ));
    operator_panel_model panel (.sys_clk_in(sys_clk), .ctl_src_out(src), .xmit_key_out(xk),
        .reset_key_out(rk));

    // Clock and hang guard
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            err_total++;
            give_verdict();
        end
    end

    function automatic logic outsel(input int s);
        case (s)
            0: return hv;
            1: return stby;
            2: return tx;
            default: return flt;
        endcase
    endfunction : outsel
    // Bounded wait for a lamp, then judge it
    task automatic wait_chk(input int s, input logic v, input int lim, input string nm);
        int n;
        n = 0;
        while (outsel(s) !== v && n < lim)
        begin
            @(negedge sys_clk);
            n++;
        end
        `CHK(nm, v, outsel(s))
    endtask : wait_chk
    // A lamp must not move for the given number of cycles
    task automatic hold_chk(input int s, input logic v, input int lim, input string nm);
        logic ok;
        ok = 1'b1;
        repeat (lim)
        begin
            @(negedge sys_clk);
            ok &= (outsel(s) === v);
        end
        `CHK(nm, 1'b1, ok)
    endtask : hold_chk

    task automatic t_start();
        wait_chk(1, 1'b1, 60 * TC, "standby lamp");
        `CHK("hv idle", 1'b0, hv)
        panel.press(1'b0, 2'h0);
        wait_chk(0, 1'b1, 4, "beam on");
        wait_chk(2, 1'b1, 6 * TC, "transmit");
        `CHK("heater full", 7'h64, heat)
        $display("test start done");
    endtask : t_start
    task automatic t_low_rf();
        setp = 12'h200;
        fwd  = 12'h100;
        repeat (3) @(negedge sys_clk);
        `CHK("low rf", 1'b1, lowrf)
        fwd = 12'h300;
        repeat (3) @(negedge sys_clk);
        `CHK("rf ok", 1'b0, lowrf)
        // Remote desk drops to standby and brings the beam back
        panel.press(1'b0, 2'h1);
        wait_chk(1, 1'b1, 4, "key to standby");
        `CHK("hv dropped", 1'b0, hv)
        panel.press(1'b0, 2'h1);
        wait_chk(2, 1'b1, 6 * TC, "standby to tx");
        $display("test low_rf done");
    endtask : t_low_rf
    // A fault of three ticks, well under the transient limit
    task automatic t_transient(input logic rf, input logic recyc);
        if (rf)
            refl = 1'b1;
        else
            fault = 8'h01;
        repeat (2) @(negedge sys_clk);
        `CHK("fault lamp", 1'b1, flt)
        `CHK("tx off", 1'b0, tx)
        `CHK("summary", 1'b1, rf ? summ[NF] : summ[0])
        repeat (3 * TC) @(negedge sys_clk);
        refl  = 1'b0;
        fault = 8'h00;
        if (recyc)
        begin
            hold_chk(2, 1'b0, 3 * TC, "recycle delay");
            wait_chk(2, 1'b1, 8 * TC, "recycled");
        end
        else
            hold_chk(3, 1'b1, 12 * TC, "third fault latch");
        $display("test transient done");
    endtask : t_transient
    // A second fault during the recycle wait must latch
    task automatic t_refault();
        fault = 8'h08;
        repeat (2) @(negedge sys_clk);
        fault = 8'h00;
        repeat (2 * TC) @(negedge sys_clk);
        `CHK("in recycle wait", 1'b0, tx)
        fault = 8'h10;
        repeat (2) @(negedge sys_clk);
        fault = 8'h00;
        hold_chk(3, 1'b1, 10 * TC, "failed recycle");
        `CHK("summary bits", 9'h018, summ)
        $display("test refault done");
    endtask : t_refault
    // Reset refused while a fault stands, then accepted twice, one press per desk
    task automatic t_reset_resume();
        fault = 8'h02;
        panel.press(1'b1, 2'h0);
        hold_chk(3, 1'b1, 4, "reset refused");
        `CHK("heater low", 7'h5a, heat)
        fault = 8'h00;
        panel.press(1'b1, 2'h1);
        wait_chk(1, 1'b1, 8, "standby after reset");
        `CHK("fault off", 1'b0, flt)
        `CHK("summary clear", 9'h000, summ)
        panel.press(1'b1, 2'h2);
        wait_chk(0, 1'b1, 8, "resume beam");
        wait_chk(2, 1'b1, 6 * TC, "resume tx");
        `CHK("heater back", 7'h64, heat)
        $display("test reset_resume done");
    endtask : t_reset_resume
    task automatic t_outage();
        ac_ok = 1'b0;
        repeat (TC) @(negedge sys_clk);
        ac_ok = 1'b1;
        wait_chk(2, 1'b1, 8 * TC, "short outage");
        ac_ok = 1'b0;
        repeat (30 * TC) @(negedge sys_clk);
        ac_ok = 1'b1;
        hold_chk(0, 1'b0, 12 * TC, "outage warmup");
        wait_chk(2, 1'b1, 18 * TC, "warmup capped");
        // Eight ticks out gives eight ticks of warm-up, well short of the cap
        ac_ok = 1'b0;
        repeat (8 * TC) @(negedge sys_clk);
        ac_ok = 1'b1;
        hold_chk(0, 1'b0, 4 * TC, "short warmup");
        wait_chk(2, 1'b1, 11 * TC, "warmup proportional");
        $display("test outage done");
    endtask : t_outage
    task automatic t_pending();
        rstn = 1'b0;
        repeat (16) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (3 * TC) @(negedge sys_clk);
        `CHK("no flash idle", 1'b0, stby)
        panel.press(1'b0, 2'h2);
        `CHK("request flash", 1'b1, stby)
        hold_chk(0, 1'b0, 8, "held in warmup");
        wait_chk(2, 1'b1, 30 * TC, "auto beam on");
        $display("test pending done");
    endtask : t_pending

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    // Main sequence, inputs move on the falling edge only
    initial
    begin
        rstn  = 1'b0;
        ac_ok = 1'b1;
        refl  = 1'b0;
        fault = 8'h00;
        fwd   = 12'h000;
        setp  = 12'h000;
        repeat (16) @(negedge sys_clk);
        rstn = 1'b1;
        t_start();
        t_low_rf();
        t_transient(1'b1, 1'b1);
        // Let the fault window drain before counting three
        repeat (40 * TC) @(negedge sys_clk);
        t_transient(1'b0, 1'b1);
        t_transient(1'b0, 1'b1);
        t_transient(1'b0, 1'b0);
        t_reset_resume();
        repeat (40 * TC) @(negedge sys_clk);
        t_refault();
        t_reset_resume();
        repeat (40 * TC) @(negedge sys_clk);
        // Sensor bits 2, 5, 6 and 7 of a long fault must all reach the summary
        fault = 8'he4;
        repeat (12 * TC) @(negedge sys_clk);
        fault = 8'h00;
        hold_chk(3, 1'b1, 8 * TC, "long fault latch");
        `CHK("long summary", 9'h0e4, summ)
        t_reset_resume();
        t_outage();
        t_pending();
        give_verdict();
    end
endmodule : amplifier_beam_fault_sequencer_test
`default_nettype wire
